// >>> verilog/gms_sequencer.sv
// Operation
// RULE1 - Tunnel operation waits for start command
// RULE2 - Forward first descriptor fragments unaltered
// RULE3 - Forward new descriptor on change count
// RULE4 - Invalid descriptor resumes channel scanning
// RULE5 - Report failed full scan, keep scanning
// RULE6 - Use default timers unless overridden
// RULE7 - Overrides persist until reset or override
// RULE8 - Init timeout two seconds, range 1-65535
// RULE9 - Operational timeout defaults to 600 seconds
// RULE10 - Retry timer 300 seconds, zero continuous
// RULE11 - Rescan timer 1800 seconds, zero immediate
// RULE12 - Rescan expiry starts new channel search
// RULE13 - Retry expiry starts upstream reconnection
// RULE14 - Stay tuned while upstream is lost
// RULE15 - MAC reinit conditions enter one-way mode
// RULE16 - One-way mode periodically retries upstream
// RULE17 - Each retry restarts upstream acquisition
// RULE18 - Accept channel only when controller validates
// RULE19 - Report forwarding limitations to controller
// RULE20 - Channel-change depart notifies with type
// RULE21 - Channel-change arrive sends two-way-ok 255
// RULE22 - Depart notice precedes bonding-change response
// RULE23 - Bonding success sends two-way-ok 255
// RULE24 - Commands accepted in every state
// RULE25 - Newer version keeps sequence with any headend
// RULE26 - Messages are enumerated codes with fields
module gms_sequencer #(
    parameter int unsigned TICKS = gms_pkg::TICK_CYCLES
) (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic newer_ver_in,
    input wire logic cmd_valid_in,
    input wire gms_pkg::gms_cmd_t cmd_code_in,
    input wire logic [1:0] cmd_sel_in,
    input wire logic [15:0] cmd_arg_in,
    input wire logic tunnel_pkt_in,
    input wire logic scan_complete_in,
    input wire logic mac_reinit_in,
    input wire logic us_ok_in,
    input wire logic dcc_depart_in,
    input wire logic [7:0] dcc_type_in,
    input wire logic dcc_arrive_in,
    input wire logic dbc_req_in,
    input wire logic dbc_done_in,
    input wire logic fwd_limit_in,
    input wire logic [7:0] naco_in,
    input wire logic [7:0] max_cpe_in,
    input wire logic frag_valid_in,
    input wire logic frag_first_in,
    input wire logic frag_last_in,
    input wire logic [7:0] frag_cc_in,
    input wire logic [gms_pkg::FRAG_W-1:0] frag_data_in,
    output logic frag_ready_out,
    output logic fwd_valid_out,
    output logic [gms_pkg::FRAG_W-1:0] fwd_data_out,
    output logic fwd_last_out,
    input wire logic fwd_ready_in,
    output logic notif_valid_out,
    output gms_pkg::gms_note_t notif_code_out,
    output logic [15:0] notif_param_out,
    output logic gateway_active_out,
    output logic tune_hold_out,
    output logic one_way_out,
    output logic scan_req_out,
    output logic us_acquire_start_out,
    output logic us_mode_out,
    output logic us_tx_enable_out,
    output logic dbc_rsp_go_out
);
    import gms_pkg::*;

    gms_state_t st_q, st_d;
    logic [15:0] tval_q [TMR_NUM];
    logic [15:0] tval_d [TMR_NUM];
    logic [TMR_NUM-1:0] t_start, t_stop, t_exp;
    logic scan_q, scan_d, acq_q, acq_d, ustx_q, ustx_d;
    logic mode_q, mode_d, strap_q, strap_d;
    logic [NP_NUM-1:0] pend_q, pend_d, pick, ev;
    logic [7:0] dtype_q, dtype_d;
    logic [15:0] lim_q, lim_d;
    logic nv_q, nv_d, dbcw_q, dbcw_d, arm_q, arm_d, go_q, go_d;
    gms_note_t nc_q, nc_d;
    logic [15:0] np_q, np_d;
    logic have_cc_q, have_cc_d, fon_q, fon_d;
    logic [7:0] cc_q, cc_d;
    logic keep, frag_take;
    logic cmd_go;

    assign cmd_go = cmd_valid_in; // RULE24

    // Four second timers; values start at defaults and change only on
    // a controller override, so only a reboot or another override brings them back.
    for (genvar i = 0; i < TMR_NUM; i++) begin : g_tmr
        gms_sec_timer #(.TICKS(TICKS)) u_tmr (
            .mclk_in(mclk_in),
            .reset_in(reset_in),
            .start_in(t_start[i]),
            .stop_in(t_stop[i]),
            .secs_in(tval_q[i]),
            .expire_out(t_exp[i]),
            .busy_out()
        );
    end

    // Sequencing state machine; commands are decoded in every state.
    always_comb begin
        st_d = st_q;
        t_start = '0;
        t_stop = '0;
        scan_d = 1'b0;
        acq_d = 1'b0;
        ustx_d = ustx_q;
        tval_d = tval_q;
        ev = '0;
        // Zero would violate the 1..65535 range of the two timeouts.
        if (cmd_go && cmd_code_in == CMD_SET_TIMER) begin // RULE7
            if (cmd_arg_in != 16'h0000 || cmd_sel_in[1]) begin // RULE8
                tval_d[cmd_sel_in] = cmd_arg_in; // RULE6
            end
        end
        if (cmd_go && cmd_code_in == CMD_US_DISABLE) ustx_d = 1'b0;
        if (cmd_go && cmd_code_in == CMD_US_ENABLE) ustx_d = 1'b1;
        case (st_q)
            ST_IDLE: begin
                if (cmd_go && cmd_code_in == CMD_START) begin // RULE1
                    st_d = ST_SCAN;
                    scan_d = 1'b1;
                    t_start[TMR_INIT] = 1'b1;
                end
            end
            ST_SCAN: begin
                if (tunnel_pkt_in) begin
                    st_d = ST_CHECK;
                end else if (t_exp[TMR_INIT]) begin
                    scan_d = 1'b1;
                    t_start[TMR_INIT] = 1'b1;
                end
            end
            ST_CHECK: begin
                if (cmd_go && cmd_code_in == CMD_VALID) begin // RULE18
                    st_d = ST_UPACQ;
                    acq_d = 1'b1;
                    t_stop[TMR_INIT] = 1'b1;
                    t_start[TMR_OPER] = 1'b1;
                end else if (t_exp[TMR_INIT]) begin
                    st_d = ST_SCAN;
                    scan_d = 1'b1;
                    t_start[TMR_INIT] = 1'b1;
                end
            end
            ST_UPACQ, ST_OPER, ST_ONEWAY: begin
                if (tunnel_pkt_in) t_start[TMR_OPER] = 1'b1; // RULE14
                if (t_exp[TMR_OPER]) begin
                    st_d = ST_RESCAN;
                    t_stop[TMR_RETRY] = 1'b1;
                    t_start[TMR_RESCAN] = 1'b1; // RULE11
                end else if (mac_reinit_in && st_q != ST_ONEWAY) begin
                    st_d = ST_ONEWAY; // RULE15
                    ev[NP_ONE_WAY] = 1'b1;
                    t_start[TMR_RETRY] = 1'b1; // RULE16
                end else if (st_q == ST_UPACQ && us_ok_in) begin
                    st_d = ST_OPER;
                    ev[NP_TWO_WAY] = 1'b1;
                end else if (st_q == ST_ONEWAY && t_exp[TMR_RETRY]) begin
                    st_d = ST_UPACQ; // RULE13
                    acq_d = 1'b1; // RULE17
                end
            end
            ST_RESCAN: begin
                if (t_exp[TMR_RESCAN]) begin // RULE12
                    st_d = ST_SCAN;
                    scan_d = 1'b1;
                    t_start[TMR_INIT] = 1'b1;
                end
            end
            default: st_d = ST_IDLE;
        endcase
        // A declared-invalid channel sends the scan onward from any state except ST_IDLE.
        if (cmd_go && cmd_code_in == CMD_INVALID && st_q != ST_IDLE) begin
            st_d = ST_SCAN; // RULE4
            scan_d = 1'b1;
            t_stop = '1;
            t_start[TMR_INIT] = 1'b1;
        end
        if (scan_complete_in && (st_q == ST_SCAN || st_q == ST_CHECK)) begin
            ev[NP_SCAN_DONE] = 1'b1; // RULE5
        end
        if (dcc_depart_in || dbc_req_in) ev[NP_DEPART] = 1'b1; // RULE20
        if (dcc_arrive_in || dbc_done_in) ev[NP_TWO_WAY] = 1'b1; // RULE23
        if (fwd_limit_in) ev[NP_NO_FWD] = 1'b1; // RULE19
    end

    // Notification queue: one pending bit per kind, lowest index first.
    // A new event in the cycle its bit is sent keeps the bit set.
    always_comb begin
        pick = '0;
        for (int k = NP_NUM - 1; k >= 0; k--) begin
            if (pend_q[k]) pick = NP_NUM'(1) << k;
        end
        pend_d = (pend_q & ~pick) | ev;
        dtype_d = dcc_depart_in ? dcc_type_in : dtype_q; // RULE20
        if (dbc_req_in && !dcc_depart_in) dtype_d = 8'h00;
        lim_d = fwd_limit_in ? {naco_in, max_cpe_in} : lim_q;
        nv_d = (pick != '0);
        nc_d = NOTE_NONE;
        np_d = 16'h0000;
        if (pick[NP_DEPART]) begin
            nc_d = NOTE_DEPART;
            np_d = {8'h00, dtype_q};
        end else if (pick[NP_TWO_WAY]) begin
            nc_d = NOTE_TWO_WAY_OK; // RULE26
            np_d = {8'h00, UCID_LEGACY}; // RULE21
        end else if (pick[NP_ONE_WAY]) begin
            nc_d = NOTE_ONE_WAY;
        end else if (pick[NP_NO_FWD]) begin
            nc_d = NOTE_NO_FWD;
            np_d = lim_q;
        end else if (pick[NP_SCAN_DONE]) begin
            nc_d = NOTE_SCAN_DONE;
        end
        // The bonding response is released only after the depart notice.
        dbcw_d = dbc_req_in || (dbcw_q && !pick[NP_DEPART]);
        arm_d = pick[NP_DEPART] && dbcw_q; // RULE22
        go_d = arm_q;
        // The newer-version strap is caught once after reset release.
        strap_d = 1'b1;
        mode_d = strap_q ? mode_q : newer_ver_in; // RULE25
    end

    // Descriptor forwarding decision is made on the first fragment and
    // held for the rest; dropped fragments still complete the handshake.
    always_comb begin
        frag_take = frag_valid_in && frag_ready_out;
        keep = frag_first_in ? (!have_cc_q || frag_cc_in != cc_q) : fon_q;
        have_cc_d = have_cc_q;
        cc_d = cc_q;
        fon_d = fon_q;
        if (frag_take && frag_first_in) begin
            have_cc_d = 1'b1; // RULE2
            cc_d = frag_cc_in;
            fon_d = keep; // RULE3
        end
    end

    gms_buf2 #(.W(FRAG_W + 1)) u_buf (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .in_valid_in(frag_valid_in && keep),
        .in_data_in({frag_last_in, frag_data_in}),
        .in_ready_out(frag_ready_out),
        .out_valid_out(fwd_valid_out),
        .out_data_out({fwd_last_out, fwd_data_out}),
        .out_ready_in(fwd_ready_in)
    );

    // All state registers.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            st_q <= ST_IDLE;
            tval_q[TMR_INIT] <= INIT_TO_DEF_S; // RULE8
            tval_q[TMR_OPER] <= OPER_TO_DEF_S; // RULE9
            tval_q[TMR_RETRY] <= RETRY_DEF_S; // RULE10
            tval_q[TMR_RESCAN] <= RESCAN_DEF_S;
            scan_q <= 1'b0;
            acq_q <= 1'b0;
            ustx_q <= 1'b1;
            mode_q <= 1'b0;
            strap_q <= 1'b0;
            pend_q <= '0;
            dtype_q <= 8'h00;
            lim_q <= 16'h0000;
            nv_q <= 1'b0;
            nc_q <= NOTE_NONE;
            np_q <= 16'h0000;
            dbcw_q <= 1'b0;
            arm_q <= 1'b0;
            go_q <= 1'b0;
            have_cc_q <= 1'b0;
            cc_q <= 8'h00;
            fon_q <= 1'b0;
        end else begin
            st_q <= st_d;
            tval_q <= tval_d;
            scan_q <= scan_d;
            acq_q <= acq_d;
            ustx_q <= ustx_d;
            mode_q <= mode_d;
            strap_q <= strap_d;
            pend_q <= pend_d;
            dtype_q <= dtype_d;
            lim_q <= lim_d;
            nv_q <= nv_d;
            nc_q <= nc_d;
            np_q <= np_d;
            dbcw_q <= dbcw_d;
            arm_q <= arm_d;
            go_q <= go_d;
            have_cc_q <= have_cc_d;
            cc_q <= cc_d;
            fon_q <= fon_d;
        end
    end

    assign gateway_active_out = (st_q != ST_IDLE);
    assign tune_hold_out = st_q[1];
    assign one_way_out = (st_q == ST_ONEWAY);
    assign scan_req_out = scan_q;
    assign us_acquire_start_out = acq_q;
    assign us_mode_out = mode_q;
    assign us_tx_enable_out = ustx_q;
    assign notif_valid_out = nv_q;
    assign notif_code_out = nc_q;
    assign notif_param_out = np_q;
    assign dbc_rsp_go_out = go_q;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);

    sequence s_depart_sent;
        notif_valid_out && notif_code_out == NOTE_DEPART;
    endsequence

    sequence s_scan_note;
        notif_valid_out && notif_code_out == NOTE_SCAN_DONE;
    endsequence

    a_start_gate: assert property ($past(st_q == ST_IDLE) && st_q != ST_IDLE
        |-> $past(cmd_valid_in && cmd_code_in == CMD_START)) // RULE1
        else $error("tunnel operation began without start command");
    a_first_frag: assert property (frag_take && frag_first_in && !have_cc_q
        |=> fon_q && have_cc_q) // RULE2
        else $error("first descriptor not forwarded");
    a_cc_change: assert property (frag_take && frag_first_in && have_cc_q
        && frag_cc_in != cc_q |=> fon_q && cc_q == $past(frag_cc_in)) // RULE3
        else $error("changed descriptor not forwarded");
    a_invalid_hunt: assert property (cmd_valid_in && st_q != ST_IDLE
        && cmd_code_in == CMD_INVALID |=> st_q == ST_SCAN && scan_q) // RULE4
        else $error("invalid channel did not resume scan");
    a_scan_report: assert property (scan_complete_in && st_q == ST_SCAN
        |-> ##[1:8] s_scan_note) // RULE5
        else $error("failed scan not reported");
    a_reinit_oneway: assert property ((st_q == ST_OPER || st_q == ST_UPACQ)
        && mac_reinit_in && !t_exp[TMR_OPER] && !(cmd_valid_in
        && cmd_code_in == CMD_INVALID) |=> one_way_out) // RULE15
        else $error("reinit condition did not enter one-way mode");
    a_retry_acq: assert property (st_q == ST_ONEWAY && t_exp[TMR_RETRY]
        && !t_exp[TMR_OPER] && !cmd_valid_in
        |=> us_acquire_start_out && st_q == ST_UPACQ) // RULE13
        else $error("retry expiry did not restart acquisition");
    a_ucid_fixed: assert property (notif_valid_out
        && notif_code_out == NOTE_TWO_WAY_OK
        |-> notif_param_out == {8'h00, UCID_LEGACY}) // RULE21
        else $error("two-way-ok carries wrong channel id");
    a_depart_first: assert property (dbc_rsp_go_out
        |-> $past(notif_valid_out && notif_code_out == NOTE_DEPART)) // RULE22
        else $error("bonding response before depart notice");
    a_dbc_release: assert property (s_depart_sent and $past(dbcw_q)
        |=> dbc_rsp_go_out) // RULE22
        else $error("bonding response not released");
    a_hold_tuned: assert property (one_way_out |-> tune_hold_out) // RULE14
        else $error("tuning released in one-way mode");
endmodule

// >>> verilog/gms_pkg.sv
package gms_pkg;

    // One second of timer resolution, and its length in clock cycles.
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned TICK_S = 1;
    localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_S;

    // Default timer values in seconds.
    localparam logic [15:0] INIT_TO_DEF_S = 16'h0002;
    localparam logic [15:0] OPER_TO_DEF_S = 16'h0258;
    localparam logic [15:0] RETRY_DEF_S = 16'h012C;
    localparam logic [15:0] RESCAN_DEF_S = 16'h0708;

    // Upstream channel identifier reported in every two-way-ok message.
    localparam logic [7:0] UCID_LEGACY = 8'hFF;

    // Timer slots.
    localparam int unsigned TMR_INIT = 0;
    localparam int unsigned TMR_OPER = 1;
    localparam int unsigned TMR_RETRY = 2;
    localparam int unsigned TMR_RESCAN = 3;
    localparam int unsigned TMR_NUM = 4;

    // Pending notification slots, lowest index sent first.
    localparam int unsigned NP_DEPART = 0;
    localparam int unsigned NP_TWO_WAY = 1;
    localparam int unsigned NP_ONE_WAY = 2;
    localparam int unsigned NP_NO_FWD = 3;
    localparam int unsigned NP_SCAN_DONE = 4;
    localparam int unsigned NP_NUM = 5;

    // Descriptor fragment word width.
    localparam int unsigned FRAG_W = 32;

    typedef enum logic [3:0] {
        CMD_NOP = 4'h0,
        CMD_START = 4'h1,
        CMD_VALID = 4'h2,
        CMD_INVALID = 4'h3,
        CMD_SET_TIMER = 4'h4,
        CMD_US_DISABLE = 4'h5,
        CMD_US_ENABLE = 4'h6
    } gms_cmd_t;

    typedef enum logic [3:0] {
        NOTE_NONE = 4'h0,
        NOTE_DEPART = 4'h1,
        NOTE_TWO_WAY_OK = 4'h2,
        NOTE_ONE_WAY = 4'h3,
        NOTE_NO_FWD = 4'h4,
        NOTE_SCAN_DONE = 4'h5
    } gms_note_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SCAN = 3'b001,
        ST_CHECK = 3'b011,
        ST_UPACQ = 3'b010,
        ST_OPER = 3'b110,
        ST_ONEWAY = 3'b111,
        ST_RESCAN = 3'b101
    } gms_state_t;

endpackage

// >>> verilog/gms_sec_timer.sv
// Second-granular down counter; a load of zero expires on the next edge.
module gms_sec_timer #(
    parameter int unsigned TICKS = gms_pkg::TICK_CYCLES
) (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic start_in,
    input wire logic stop_in,
    input wire logic [15:0] secs_in,
    output logic expire_out,
    output logic busy_out
);
    import gms_pkg::*;

    logic [31:0] pre_q, pre_d;
    logic [15:0] secs_q, secs_d;
    logic busy_q, busy_d;
    logic exp_q, exp_d;

    // Restart wins over stop so a retrigger in the same cycle is kept.
    always_comb begin
        pre_d = pre_q;
        secs_d = secs_q;
        busy_d = busy_q;
        exp_d = 1'b0;
        if (start_in) begin
            pre_d = 32'h0000_0000;
            secs_d = secs_in;
            busy_d = 1'b1;
        end else if (stop_in) begin
            busy_d = 1'b0;
        end else if (busy_q) begin
            if (secs_q == 16'h0000) begin
                exp_d = 1'b1;
                busy_d = 1'b0;
            end else if (pre_q == 32'(TICKS - 1)) begin
                pre_d = 32'h0000_0000;
                secs_d = secs_q - 16'h0001;
            end else begin
                pre_d = pre_q + 32'h0000_0001;
            end
        end
    end

    // Count state.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            pre_q <= 32'h0000_0000;
            secs_q <= 16'h0000;
            busy_q <= 1'b0;
            exp_q <= 1'b0;
        end else begin
            pre_q <= pre_d;
            secs_q <= secs_d;
            busy_q <= busy_d;
            exp_q <= exp_d;
        end
    end

    assign expire_out = exp_q;
    assign busy_out = busy_q;
endmodule

// >>> verilog/gms_buf2.sv
// Two-entry buffer; both handshake flags come straight from flip-flops.
module gms_buf2 #(
    parameter int unsigned W = gms_pkg::FRAG_W + 1
) (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic in_valid_in,
    input wire logic [W-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [W-1:0] out_data_out,
    input wire logic out_ready_in
);
    import gms_pkg::*;

    logic [W-1:0] mem_q [2];
    logic [W-1:0] mem_d [2];
    logic wp_q, wp_d, rp_q, rp_d;
    logic [1:0] cnt_q, cnt_d;
    logic rdy_q, rdy_d, vld_q, vld_d;
    logic push, pop;

    // Pointer and count update; ready drops as soon as two words are held.
    always_comb begin
        push = in_valid_in && rdy_q;
        pop = vld_q && out_ready_in;
        mem_d = mem_q;
        wp_d = wp_q;
        rp_d = rp_q;
        cnt_d = cnt_q;
        if (push) begin
            mem_d[wp_q] = in_data_in;
            wp_d = ~wp_q;
        end
        if (pop) begin
            rp_d = ~rp_q;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 2'd1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 2'd1;
        end
        rdy_d = (cnt_d != 2'd2);
        vld_d = (cnt_d != 2'd0);
    end

    // Storage and flags.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'd0;
            rdy_q <= 1'b1;
            vld_q <= 1'b0;
        end else begin
            mem_q <= mem_d;
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
            vld_q <= vld_d;
        end
    end

    assign in_ready_out = rdy_q;
    assign out_valid_out = vld_q;
    assign out_data_out = mem_q[rp_q];
endmodule

// >>> tb/gms_ctl_model.sv
// Client controller side; it records each word.
module gms_ctl_model (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic stall_in,
    input wire logic fwd_valid_in,
    input wire logic [gms_pkg::FRAG_W-1:0] fwd_data_in,
    input wire logic fwd_last_in,
    output logic fwd_ready_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [gms_pkg::FRAG_W-1:0] got_data [0:15];
    logic got_last [0:15];
    int got_cnt;

    // A stall holds ready low so that the buffer fills up.
    assign fwd_ready_out = ~stall_in;

    // Words are taken only at an edge where valid and ready are both high.
    always @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            got_cnt <= 0;
        end else if (fwd_valid_in === 1'b1 && fwd_ready_out) begin
            got_data[got_cnt[3:0]] <= fwd_data_in;
            got_last[got_cnt[3:0]] <= fwd_last_in;
            got_cnt <= got_cnt + 1;
        end
    end
endmodule

// >>> tb/tb_top.sv
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import gms_pkg::*;
    logic mclk_in = 1'b0;
    logic reset_in = 1'b1;
    logic cmd_valid_in = 1'b0;
    gms_cmd_t cmd_code_in = CMD_NOP;
    logic [1:0] cmd_sel_in = 2'h0;
    logic [15:0] cmd_arg_in = 16'h0000;
    logic [8:0] ev = 9'h000;
    logic [7:0] dcc_type = 8'h5A;
    logic frag_valid_in = 1'b0;
    logic frag_first_in = 1'b0;
    logic frag_last_in = 1'b0;
    logic [7:0] frag_cc_in = 8'h00;
    logic [31:0] frag_data_in = 32'h0000_0000;
    logic stall = 1'b0, newer = 1'b1;
    logic frag_ready_out, fwd_valid_out, fwd_last_out, fwd_ready;
    logic [31:0] fwd_data_out;
    logic notif_valid_out, gateway_active_out, tune_hold_out, one_way_out;
    gms_note_t notif_code_out;
    logic [15:0] notif_param_out;
    logic scan_req_out, us_acquire_start_out, us_mode_out;
    logic us_tx_enable_out, dbc_rsp_go_out, saw_full = 1'b0;
    int err_total = 0, total_checks = 0, scan_cnt = 0, acq_cnt = 0;
    logic [19:0] nq [$];

    gms_sequencer #(.TICKS(4)) i_dut (.mclk_in, .reset_in,
        .newer_ver_in(newer), .cmd_valid_in, .cmd_code_in, .cmd_sel_in,
        .cmd_arg_in, .tunnel_pkt_in(ev[0]), .scan_complete_in(ev[1]),
        .mac_reinit_in(ev[2]), .us_ok_in(ev[3]), .dcc_depart_in(ev[4]),
        .dcc_type_in(dcc_type), .dcc_arrive_in(ev[5]), .dbc_req_in(ev[6]),
        .dbc_done_in(ev[7]), .fwd_limit_in(ev[8]), .naco_in(8'h12),
        .max_cpe_in(8'h34), .frag_valid_in, .frag_first_in, .frag_last_in,
        .frag_cc_in, .frag_data_in, .frag_ready_out, .fwd_valid_out,
        .fwd_data_out, .fwd_last_out, .fwd_ready_in(fwd_ready),
        .notif_valid_out, .notif_code_out, .notif_param_out,
        .gateway_active_out, .tune_hold_out, .one_way_out, .scan_req_out,
        .us_acquire_start_out, .us_mode_out, .us_tx_enable_out,
        .dbc_rsp_go_out);
    gms_ctl_model i_ctl (.mclk_in, .reset_in, .stall_in(stall),
        .fwd_valid_in(fwd_valid_out), .fwd_data_in(fwd_data_out),
        .fwd_last_in(fwd_last_out), .fwd_ready_out(fwd_ready));

    always #25 mclk_in = ~mclk_in;

    // Pulses are counted and notifications queued.
    always @(posedge mclk_in) begin
        if (notif_valid_out === 1'b1)
            nq.push_back({notif_code_out, notif_param_out});
        if (scan_req_out === 1'b1) scan_cnt++;
        if (us_acquire_start_out === 1'b1) acq_cnt++;
        if (frag_ready_out === 1'b0) saw_full = 1'b1;
    end

    task automatic finish_test;
        if (err_total == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
    endtask
    task automatic pulse(input int i);
        ev[i] <= 1'b1;
        tick(1);
        ev <= 9'h000;
        tick(1);
    endtask
    task automatic cmd(gms_cmd_t c, logic [1:0] s, logic [15:0] a);
        cmd_code_in <= c;
        cmd_sel_in <= s;
        cmd_arg_in <= a;
        cmd_valid_in <= 1'b1;
        tick(1);
        cmd_valid_in <= 1'b0;
        tick(1);
    endtask
    // Waits a bounded time for the next notification.
    task automatic note(gms_note_t c, logic [15:0] p);
        int n;
        logic [19:0] got;
        n = 0;
        while (nq.size() == 0 && n < 20) begin
            tick(1);
            n++;
        end
        got = (nq.size() != 0) ? nq.pop_front() : 20'hFFFFF;
        `CHK(got, {c, p})
    endtask
    // One descriptor per burst.
    task automatic desc(logic [7:0] cc, int n, logic [31:0] base);
        for (int k = 0; k < n; k++) begin
            frag_first_in <= (k == 0);
            frag_last_in <= (k == n - 1);
            frag_cc_in <= cc;
            frag_data_in <= base + 32'(k);
            frag_valid_in <= 1'b1;
            do tick(1); while (frag_ready_out !== 1'b1);
        end
        frag_valid_in <= 1'b0;
        tick(1);
    endtask

    task automatic t_idle;
        `CHK(frag_ready_out, 1'b1)
        `CHK(us_tx_enable_out, 1'b1)
        pulse(0);
        pulse(3);
        tick(2);
        `CHK(gateway_active_out, 1'b0)
        `CHK(scan_cnt, 0)
    endtask
    task automatic t_start;
        cmd(CMD_START, 2'h0, 16'h0000);
        tick(1);
        `CHK(gateway_active_out, 1'b1)
        `CHK(scan_cnt, 1)
        tick(12);
        `CHK(scan_cnt, 2)
        cmd(CMD_SET_TIMER, 2'h0, 16'hFFFF);
        cmd(CMD_SET_TIMER, 2'h1, 16'hFFFF);
    endtask
    // Repeated change count is dropped; a stall makes the input refuse.
    task automatic t_frag;
        desc(8'h01, 2, 32'hA000_0000);
        desc(8'h01, 2, 32'hB000_0000);
        stall <= 1'b1;
        fork
            desc(8'h02, 3, 32'hC000_0000);
            begin tick(8); stall <= 1'b0; end
        join
        tick(4);
        `CHK(i_ctl.got_cnt, 5)
        `CHK(i_ctl.got_data[1], 32'hA000_0001)
        `CHK(i_ctl.got_data[4], 32'hC000_0002)
        `CHK(i_ctl.got_last[4], 1'b1)
        `CHK(saw_full, 1'b1)
    endtask
    task automatic t_scan;
        int s;
        pulse(1);
        note(NOTE_SCAN_DONE, 16'h0000);
        s = scan_cnt;
        pulse(0);
        cmd(CMD_INVALID, 2'h0, 16'h0000);
        tick(2);
        `CHK(scan_cnt, s + 1)
        cmd(CMD_VALID, 2'h0, 16'h0000);
        tick(1);
        `CHK(acq_cnt, 0)
        pulse(0);
        cmd(CMD_VALID, 2'h0, 16'h0000);
        tick(1);
        `CHK(acq_cnt, 1)
        `CHK(us_mode_out, 1'b1)
    endtask
    task automatic t_link;
        pulse(3);
        note(NOTE_TWO_WAY_OK, 16'h00FF);
        pulse(2);
        note(NOTE_ONE_WAY, 16'h0000);
        `CHK(one_way_out, 1'b1)
        `CHK(tune_hold_out, 1'b1)
        cmd(CMD_SET_TIMER, 2'h2, 16'h0000);
        cmd(CMD_US_DISABLE, 2'h0, 16'h0000);
        `CHK(us_tx_enable_out, 1'b0)
        cmd(CMD_US_ENABLE, 2'h0, 16'h0000);
        `CHK(us_tx_enable_out, 1'b1)
        tick(1100);
        `CHK(acq_cnt, 1)
        tick(200);
        `CHK(acq_cnt, 2)
        pulse(2);
        tick(6);
        `CHK(acq_cnt, 3)
        cmd(CMD_SET_TIMER, 2'h1, 16'h0001);
        pulse(0);
        tick(7100);
        `CHK(scan_cnt, 4)
        tick(110);
        `CHK(scan_cnt, 5)
    endtask
    task automatic t_chan;
        int n;
        nq.delete();
        pulse(4);
        note(NOTE_DEPART, 16'h005A);
        pulse(5);
        note(NOTE_TWO_WAY_OK, 16'h00FF);
        pulse(8);
        note(NOTE_NO_FWD, 16'h1234);
        dcc_type <= 8'h00;
        pulse(6);
        n = 0;
        while (dbc_rsp_go_out !== 1'b1 && n < 10) begin
            tick(1);
            n++;
        end
        `CHK(nq.size() != 0, 1'b1)
        note(NOTE_DEPART, 16'h0000);
        pulse(7);
        note(NOTE_TWO_WAY_OK, 16'h00FF);
    endtask
    task automatic t_boot;
        newer <= 1'b0;
        reset_in <= 1'b1;
        tick(1);
        reset_in <= 1'b0;
        tick(1);
        newer <= 1'b1;
        tick(2);
        `CHK(us_mode_out, 1'b0)
    endtask

    // Main sequence; reset spans four clock cycles.
    initial begin
        tick(4);
        reset_in <= 1'b0;
        tick(1);
        t_idle();
        t_start();
        t_frag();
        t_scan();
        t_link();
        t_chan();
        t_boot();
        finish_test();
    end

    // Cuts a hang short.
    initial begin
        tick(12000);
        err_total++;
        finish_test();
    end
endmodule
